// File: inc/lvic_pkg.sv
// Constants, register map and types of the low-voltage interrupt control block
package lvic_pkg;

  // Bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W  = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IE_BIT   = 1;
  localparam int CTRL_STAT_BIT = 2;
  localparam int CTRL_W        = 3;

  // Mode register fields
  localparam int MODE_LSB     = 0;
  localparam int MODE_W       = 2;
  localparam int MODE_PIN_BIT = 2;
  localparam int MODE_STOP_BIT = 3;

  // Event status and mask fields
  localparam int IRQ_LV_BIT   = 0;
  localparam int IRQ_PIN_BIT  = 1;
  localparam int IRQ_STOP_BIT = 2;
  localparam int IRQ_W        = 3;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST     = 3'h0;
  localparam logic [IRQ_W-1:0]  IRQ_STAT_RST = 3'h0;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    LVIC_SHUTDOWN,
    LVIC_FULL_PERF,
    LVIC_REDUCED
  } lvic_mode_t;

endpackage

// File: inc/lvic_if.sv
// Carrier between the detection front end and the register bank
`timescale 1ns/10ps
interface lvic_if;
  logic                ce;
  logic                stop_mode;
  logic                lv_status;
  logic                lv_change;
  logic                pin_level;
  logic                pin_change;
  lvic_pkg::lvic_mode_t mode;

  modport det
  (
    input  ce,
    input  stop_mode,
    output lv_status,
    output lv_change,
    output pin_level,
    output pin_change,
    output mode
  );

  modport ctl
  (
    output ce,
    output stop_mode,
    input  lv_status,
    input  lv_change,
    input  pin_level,
    input  pin_change,
    input  mode
  );
endinterface

// File: src/lvic_detect.sv
// Pin synchronisers, mode decode and low-voltage status with hysteresis
`timescale 1ns/10ps
module lvic_detect
(
  // Clock and reset
  input  wire logic CLK,
  input  wire logic SRST,
  // Asynchronous pins
  input  wire logic LV_BELOW,
  input  wire logic LV_ABOVE,
  input  wire logic REGEN,
  // Towards the register bank
  lvic_if.det       lnk
);

  logic [2:0]           sync1_r;
  logic [2:0]           sync2_r;
  logic                 pin_prev_r;
  logic [lvic_pkg::SYNC_STAGES:0] pin_seen_r;
  logic                 status_r;
  logic                 status_nxt;
  logic                 change_r;
  logic                 pin_chg_r;
  lvic_pkg::lvic_mode_t mode_r;
  lvic_pkg::lvic_mode_t mode_nxt;

  // Only the second stage is read
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end
    else if (lnk.ce)
    begin
      sync1_r <= {REGEN, LV_ABOVE, LV_BELOW};
      sync2_r <= sync1_r;
    end
  end

  always_comb
  begin
    if (!sync2_r[2])
      mode_nxt = lvic_pkg::LVIC_SHUTDOWN;
    else if (lnk.stop_mode)
      mode_nxt = lvic_pkg::LVIC_REDUCED;
    else
      mode_nxt = lvic_pkg::LVIC_FULL_PERF;
  end

  // Detection is off outside full performance, so status falls there
  always_comb
  begin
    if (mode_nxt != lvic_pkg::LVIC_FULL_PERF)
      status_nxt = 1'b0;
    else if (sync2_r[0])
      status_nxt = 1'b1;
    else if (sync2_r[1])
      status_nxt = 1'b0;
    else
      status_nxt = status_r;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mode_r   <= lvic_pkg::LVIC_SHUTDOWN;
      status_r <= 1'b0;
      change_r <= 1'b0;
    end
    else if (lnk.ce)
    begin
      mode_r   <= mode_nxt;
      status_r <= status_nxt;
      change_r <= status_nxt != status_r;
    end
  end

  // Compare only once the previous sample is a real pin level, not the reset
  // value still in the synchroniser; the first real level is the strap
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_prev_r <= 1'b0;
      pin_seen_r <= '0;
      pin_chg_r  <= 1'b0;
    end
    else if (lnk.ce)
    begin
      pin_prev_r <= sync2_r[2];
      pin_seen_r <= {pin_seen_r[lvic_pkg::SYNC_STAGES-1:0], 1'b1};
      pin_chg_r  <= pin_seen_r[lvic_pkg::SYNC_STAGES]
                    && (pin_prev_r != sync2_r[2]);
    end
  end

  assign lnk.mode       = mode_r;
  assign lnk.lv_status  = status_r;
  assign lnk.lv_change  = change_r;
  assign lnk.pin_level  = pin_prev_r;
  assign lnk.pin_change = pin_chg_r;

endmodule

// File: src/lvic_top.sv
// Register bank and interrupt logic of the low-voltage interrupt control block
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
module lvic_top
(
  // Clock, reset and clock enable
  input  wire logic                         CLK,
  input  wire logic                         SRST,
  input  wire logic                         CE,
  // Wishbone classic slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [lvic_pkg::ADDR_W-1:0]  WB_ADR_I,
  input  wire logic [lvic_pkg::SEL_W-1:0]   WB_SEL_I,
  input  wire logic [lvic_pkg::DATA_W-1:0]  WB_DAT_I,
  output logic      [lvic_pkg::DATA_W-1:0]  WB_DAT_O,
  output logic                              WB_ACK_O,
  // Comparator and pin inputs, asynchronous
  input  wire logic                         LV_BELOW_ASSERT,
  input  wire logic                         LV_ABOVE_DEASSERT,
  input  wire logic                         REGULATOR_ENABLE_PIN,
  // Processor state, same clock
  input  wire logic                         STOP_MODE,
  // Status and interrupts
  output logic      [lvic_pkg::MODE_W-1:0]  OPERATING_MODE,
  output logic                              LOW_VOLTAGE_STATUS,
  output logic                              LOW_VOLTAGE_INTERRUPT,
  output logic                              IRQ
);

  lvic_if lnk ();

  logic                        access;
  logic                        wr_stb;
  logic                        rd_stb;
  logic                        sel_lo;
  logic                        hit_ctrl;
  logic                        hit_mode;
  logic                        hit_stat;
  logic                        hit_mask;
  logic                        ack_r;
  logic [lvic_pkg::DATA_W-1:0] rdata_r;
  logic [lvic_pkg::DATA_W-1:0] rdata_nxt;
  logic                        irq_en_r;
  logic                        flag_r;
  logic                        flag_nxt;
  logic                        flag_clr;
  logic [lvic_pkg::IRQ_W-1:0]  ev_stat_r;
  logic [lvic_pkg::IRQ_W-1:0]  ev_stat_nxt;
  logic [lvic_pkg::IRQ_W-1:0]  ev_set;
  logic [lvic_pkg::IRQ_W-1:0]  ev_clr;
  logic [lvic_pkg::IRQ_W-1:0]  ev_mask_r;
  logic                        stop_entry;
  lvic_pkg::lvic_mode_t        mode_prev_r;
  logic [lvic_pkg::MODE_W-1:0] mode_out_r;
  logic                        status_out_r;
  logic                        lvi_r;
  logic                        irq_r;

  assign lnk.ce        = CE;
  assign lnk.stop_mode = STOP_MODE;

  lvic_detect u_detect
  (
    .CLK      (CLK),
    .SRST     (SRST),
    .LV_BELOW (LV_BELOW_ASSERT),
    .LV_ABOVE (LV_ABOVE_DEASSERT),
    .REGEN    (REGULATOR_ENABLE_PIN),
    .lnk      (lnk)
  );

  // Bus decode
  assign access   = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_stb   = access && WB_WE_I;
  assign rd_stb   = access && !WB_WE_I;
  assign sel_lo   = WB_SEL_I[0];
  assign hit_ctrl = WB_ADR_I == lvic_pkg::ADDR_CTRL;
  assign hit_mode = WB_ADR_I == lvic_pkg::ADDR_MODE;
  assign hit_stat = WB_ADR_I == lvic_pkg::ADDR_IRQ_STAT;
  assign hit_mask = WB_ADR_I == lvic_pkg::ADDR_IRQ_MASK;

  // One wait state: every access, mapped or not, is acknowledged once
  always_ff @(posedge CLK)
  begin
    if (SRST)
      ack_r <= 1'b0;
    else if (CE)
      ack_r <= access;
  end

  // Read data is registered with the acknowledge; idle and unmapped read zero
  always_comb
  begin
    rdata_nxt = '0;
    if (rd_stb)
    begin
      if (hit_ctrl)
      begin
        rdata_nxt[lvic_pkg::CTRL_FLAG_BIT] = flag_r;
        rdata_nxt[lvic_pkg::CTRL_IE_BIT]   = irq_en_r;
        rdata_nxt[lvic_pkg::CTRL_STAT_BIT] = lnk.lv_status;
      end
      else if (hit_mode)
      begin
        rdata_nxt[lvic_pkg::MODE_LSB +: lvic_pkg::MODE_W] = lnk.mode;
        rdata_nxt[lvic_pkg::MODE_PIN_BIT]  = lnk.pin_level;
        rdata_nxt[lvic_pkg::MODE_STOP_BIT] = STOP_MODE;
      end
      else if (hit_stat)
        rdata_nxt[lvic_pkg::IRQ_W-1:0] = ev_stat_r;
      else if (hit_mask)
        rdata_nxt[lvic_pkg::IRQ_W-1:0] = ev_mask_r;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      rdata_r <= '0;
    else if (CE)
      rdata_r <= rdata_nxt;
  end

  // Interrupt enable, bit 1 of the low byte; a one written to bit 0 clears the flag
  always_ff @(posedge CLK)
  begin
    if (SRST)
      irq_en_r <= lvic_pkg::CTRL_RST[lvic_pkg::CTRL_IE_BIT];
    else if (CE && wr_stb && hit_ctrl && sel_lo)
      irq_en_r <= WB_DAT_I[lvic_pkg::CTRL_IE_BIT];
  end

  // Change flag: a change in the clearing cycle keeps the flag set
  assign flag_clr = wr_stb && hit_ctrl && sel_lo && WB_DAT_I[lvic_pkg::CTRL_FLAG_BIT];

  always_comb
  begin
    flag_nxt = flag_r;
    if (flag_clr)
      flag_nxt = 1'b0;
    if (lnk.lv_change)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      flag_r <= lvic_pkg::CTRL_RST[lvic_pkg::CTRL_FLAG_BIT];
    else if (CE)
      flag_r <= flag_nxt;
  end

  // Events for the masked summary interrupt
  assign stop_entry = (mode_prev_r == lvic_pkg::LVIC_FULL_PERF)
                   && (lnk.mode == lvic_pkg::LVIC_REDUCED);

  always_ff @(posedge CLK)
  begin
    if (SRST)
      mode_prev_r <= lvic_pkg::LVIC_SHUTDOWN;
    else if (CE)
      mode_prev_r <= lnk.mode;
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[lvic_pkg::IRQ_LV_BIT]   = lnk.lv_change;
    ev_set[lvic_pkg::IRQ_PIN_BIT]  = lnk.pin_change;
    ev_set[lvic_pkg::IRQ_STOP_BIT] = stop_entry;
  end

  always_comb
  begin
    ev_clr = '0;
    if (wr_stb && hit_stat && sel_lo)
      ev_clr = WB_DAT_I[lvic_pkg::IRQ_W-1:0];
  end

  // Set beats clear so an event in the clearing cycle is not lost
  assign ev_stat_nxt = (ev_stat_r & ~ev_clr) | ev_set;

  always_ff @(posedge CLK)
  begin
    if (SRST)
      ev_stat_r <= lvic_pkg::IRQ_STAT_RST;
    else if (CE)
      ev_stat_r <= ev_stat_nxt;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      ev_mask_r <= lvic_pkg::IRQ_MASK_RST;
    else if (CE && wr_stb && hit_mask && sel_lo)
      ev_mask_r <= WB_DAT_I[lvic_pkg::IRQ_W-1:0];
  end

  // Interrupt outputs follow the flags one cycle later
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      lvi_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else if (CE)
    begin
      lvi_r <= irq_en_r && flag_r;
      irq_r <= |(ev_stat_r & ev_mask_r);
    end
  end

  // Mode and status mirrors on the pins
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mode_out_r   <= lvic_pkg::LVIC_SHUTDOWN;
      status_out_r <= 1'b0;
    end
    else if (CE)
    begin
      mode_out_r   <= lnk.mode;
      status_out_r <= lnk.lv_status;
    end
  end

  assign WB_ACK_O              = ack_r;
  assign WB_DAT_O              = rdata_r;
  assign OPERATING_MODE        = mode_out_r;
  assign LOW_VOLTAGE_STATUS    = status_out_r;
  assign LOW_VOLTAGE_INTERRUPT = lvi_r;
  assign IRQ                   = irq_r;

endmodule

// File: sim/lvic_top_chk.sv
// Port-level assertions for the low-voltage interrupt control block
`timescale 1ns/10ps
module lvic_top_chk
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SRST,
  // Register bus
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  // Pins and status
  input wire logic        REGULATOR_ENABLE_PIN,
  input wire logic        STOP_MODE,
  input wire logic [1:0]  OPERATING_MODE,
  input wire logic        LOW_VOLTAGE_STATUS,
  input wire logic        LOW_VOLTAGE_INTERRUPT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  // The bench drops clock enable only while the bus is idle and the mode is steady
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ctrl_rd;
    WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00;
  endsequence
  AST_ACK_NEXT: assert property (s_take |=> WB_ACK_O)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero outside ack");
  AST_UPPER_ZERO: assert property (s_ctrl_rd |-> WB_DAT_O[31:3] == 29'h0)
    else $error("unused control bits not zero");
  AST_STAT_RD: assert property (s_ctrl_rd |-> WB_DAT_O[2] == LOW_VOLTAGE_STATUS)
    else $error("status bit differs from status output");
  AST_IRQ_ON: assert property (s_ctrl_rd ##0 WB_DAT_O[1:0] == 2'h3 |=> LOW_VOLTAGE_INTERRUPT)
    else $error("interrupt missing with enable and flag set");
  AST_IRQ_OFF: assert property (s_ctrl_rd ##0 !WB_DAT_O[1] |=> !LOW_VOLTAGE_INTERRUPT)
    else $error("interrupt while disabled");
  AST_SHUTDOWN: assert property (!REGULATOR_ENABLE_PIN [*5] |-> OPERATING_MODE == 2'h0)
    else $error("not in shutdown with enable pin low");
  AST_STOP: assert property ((REGULATOR_ENABLE_PIN && STOP_MODE) [*5] |-> OPERATING_MODE == 2'h2)
    else $error("not in reduced power during stop");
  AST_FULL: assert property ((REGULATOR_ENABLE_PIN && !STOP_MODE) [*5] |-> OPERATING_MODE == 2'h1)
    else $error("not in full performance");
  AST_NOFPM_LOW: assert property ((OPERATING_MODE != 2'h1) [*3] |-> !LOW_VOLTAGE_STATUS)
    else $error("status high outside full performance");
endmodule

bind lvic_top lvic_top_chk u_lvic_top_chk
(
  .CLK, .SRST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
  .REGULATOR_ENABLE_PIN, .STOP_MODE, .OPERATING_MODE, .LOW_VOLTAGE_STATUS,
  .LOW_VOLTAGE_INTERRUPT
);

// File: sim/test_lvic_top.sv
// Self-checking bench for the low-voltage interrupt control block
`timescale 1ns/10ps
module test_lvic_top;
  logic        clk, srst, cyc, stb, we, below, above, pin, stop;
  logic        ack, lvs, low_voltage_interrupt, irq, en, fl, ce;
  logic [1:0]  mode;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q, d;
  int          bad_count, n_checks;

  lvic_top u_lvic_top
  (
    .CLK(clk), .SRST(srst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .LV_BELOW_ASSERT(below), .LV_ABOVE_DEASSERT(above), .REGULATOR_ENABLE_PIN(pin),
    .STOP_MODE(stop), .OPERATING_MODE(mode), .LOW_VOLTAGE_STATUS(lvs),
    .LOW_VOLTAGE_INTERRUPT(low_voltage_interrupt), .IRQ(irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] ctrl_v(input logic s, input logic e, input logic f);
    return {29'h0, s, e, f};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request stands until ack is sampled high at a rising edge; data is taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dv;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    chk("ack", 32'h1, 32'(ack));
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic test_done;
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0);
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    test_done;
  end

  initial
  begin
    {srst, pin, ce, sel} = {1'b1, 1'b1, 1'b1, 4'hf};
    {cyc, stb, we, below, above, stop, adr, wdat} = '0;
    bad_count = 0;
    n_checks = 0;
    d = $urandom(32'hac3d);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", ctrl_v(0, 0, 0), q);
    wb(1'b0, 8'h04, 32'h0);
    chk("mode", 32'h5, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, 8'h00, 32'h6);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", ctrl_v(0, 1, 0), q);
    below <= 1'b1;
    settle;
    chk("ctrl", ctrl_v(1, 1, 1), q);
    chk("lvi", 32'h1, 32'(low_voltage_interrupt));
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", ctrl_v(1, 1, 1), q);
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", ctrl_v(1, 1, 0), q);
    chk("lvi", 32'h0, 32'(low_voltage_interrupt));
    ce <= 1'b0;
    below <= 1'b0;
    above <= 1'b1;
    repeat (8) @(posedge clk);
    chk("frozen", 32'h1, 32'(lvs));
    ce <= 1'b1;
    settle;
    chk("ctrl", ctrl_v(0, 1, 1), q);
    wb(1'b1, 8'h00, 32'h1);
    below <= 1'b1;
    above <= 1'b0;
    settle;
    chk("ctrl", ctrl_v(1, 0, 1), q);
    chk("lvi", 32'h0, 32'(low_voltage_interrupt));
    stop <= 1'b1;
    settle;
    chk("ctrl", ctrl_v(0, 0, 1), q);
    chk("opmode", 32'h2, 32'(mode));
    wb(1'b0, 8'h08, 32'h0);
    chk("events", 32'h5, q);
    chk("irq", 32'h0, 32'(irq));
    wb(1'b1, 8'h0c, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    wb(1'b1, 8'h08, 32'h4);
    chk("irq", 32'h0, 32'(irq));
    wb(1'b0, 8'h08, 32'h0);
    chk("events", 32'h1, q);
    {en, fl} = 2'b01;
    repeat (24)
    begin
      d = $urandom;
      sel <= d[7:4];
      wb(1'b1, 8'h00, d);
      if (d[4])
        {en, fl} = {d[1], fl & ~d[0]};
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl", ctrl_v(0, en, fl), q);
    end
    // Enable pin only moves while the block is held in reset
    srst <= 1'b1;
    pin <= 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    settle;
    chk("ctrl", ctrl_v(0, 0, 0), q);
    chk("opmode", 32'h0, 32'(mode));
    test_done;
  end
endmodule
